/* hw/wdt_top.sv */
/*
 * Windowed watchdog timer: counter, timeout select, window check and
 * reset request. Configuration arrives as plain ports from the system
 * option registers; writes to the reset-status address arrive as a strobe.
 * Assumes the system reset it requests loops back onto srst.
 */
module wdt_top
	import wdt_pkg::*;
#(
	parameter int LPO_DIV = WDT_LPO_DIV
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// Configuration from the option registers
	input  wire wdt_cfg_s    cfg_in,
	input  wire logic        cfg_we,
	// Write to the reset-status address
	input  wire logic        srs_wr_en,
	input  wire logic [15:0] srs_wr_data,
	// Reset-status contents held elsewhere
	input  wire logic [7:0]  srs_status_in,
	output logic      [7:0]  reset_status_reg,
	// State visible to software
	output wdt_cfg_s         cfg_out,
	output logic             wd_enabled,
	output logic [WDT_CNT_W-1:0] count_out,
	output logic             window_open,
	// System reset request
	output logic             sys_reset_req,
	output wdt_cause_s       reset_cause
);

	wdt_cfg_s              cfg_q;        // Live configuration
	wdt_cfg_s              cfg_d;        // Next configuration
	logic [WDT_CNT_W-1:0]  cnt_q;        // Watchdog count
	logic [WDT_CNT_W-1:0]  cnt_d;        // Next count
	logic [WDT_CNT_W-1:0]  limit;        // Overflow count
	logic [WDT_CNT_W-1:0]  win_start;    // Window opening count
	logic                  lpo_tick;     // 1 kHz tick
	logic                  step;         // Count this cycle
	logic                  enabled;      // Watchdog active
	logic                  windowed;     // Window check active
	logic                  in_window;    // Count in last quarter
	logic                  overflow;     // Count reached limit
	logic                  key_first;    // First key written
	logic                  service_done; // Sequence completed
	logic                  bad_key;      // Illegal value written
	logic                  early;        // Service before window
	logic                  restart;      // Clear the count
	wdt_cause_s            cause_d;      // Reset cause this cycle
	wdt_cause_s            cause_q;      // Registered cause
	logic                  req_q;        // Registered reset request

	// Divider for the low-power tick
	wdt_tick #(
		.DIV (LPO_DIV)
	) u_tick (
		.sys_clk (sys_clk),
		.srst    (srst),
		.tick    (lpo_tick)
	);

	// Key sequence recogniser
	wdt_keyseq u_keys (
		.sys_clk      (sys_clk),
		.srst         (srst),
		.wr_en        (srs_wr_en),
		.wr_data      (srs_wr_data),
		.key_first    (key_first),
		.service_done (service_done),
		.bad_key      (bad_key)
	);

	// Zero timeout select disables regardless of source
	assign enabled = (cfg_q.timeout_select != WDT_TOSEL_OFF);

	// Source choice: 1 kHz tick or every bus clock
	assign step = cfg_q.wd_clock_select ? 1'b1 : lpo_tick;

	// Overflow limit from source and timeout
	always_comb begin
		limit = '0;
		unique case ({cfg_q.wd_clock_select, cfg_q.timeout_select})
			{1'b0, WDT_TOSEL_SHORT}: limit = WDT_CNT_W'(1 << WDT_LPO_EXP_SHORT);
			{1'b0, WDT_TOSEL_MID}:   limit = WDT_CNT_W'(1 << WDT_LPO_EXP_MID);
			{1'b0, WDT_TOSEL_LONG}:  limit = WDT_CNT_W'(1 << WDT_LPO_EXP_LONG);
			{1'b1, WDT_TOSEL_SHORT}: limit = WDT_CNT_W'(1 << WDT_BUS_EXP_SHORT);
			{1'b1, WDT_TOSEL_MID}:   limit = WDT_CNT_W'(1 << WDT_BUS_EXP_MID);
			{1'b1, WDT_TOSEL_LONG}:  limit = WDT_CNT_W'(1 << WDT_BUS_EXP_LONG);
			default:                 limit = '0;
		endcase
	end

	// Window opens at three quarters of the limit
	assign win_start = limit - (limit >> 2);
	assign in_window = (cnt_q >= win_start);

	// Window only applies on the bus clock
	assign windowed = cfg_q.window_enable && cfg_q.wd_clock_select;

	// Early service: first key write or completed pair before the window
	assign early = enabled && windowed && !in_window && (key_first || service_done);

	// Count reached the limit without service
	assign overflow = enabled && (cnt_q == limit - WDT_CNT_W'(1)) && step && !service_done;

	// Completed service restarts the timeout
	assign restart = service_done && !early;

	// Next count; cleared when disabled so re-enable starts fresh
	assign cnt_d = (!enabled || restart) ? '0 :
	               step ? cnt_q + WDT_CNT_W'(1) : cnt_q;

	// Configuration update; reset comes back enabled
	assign cfg_d = cfg_we ? cfg_in : cfg_q;

	// Reset causes; disabled watchdog never resets
	// Illegal keys only count while enabled, so a disabled
	// watchdog can never pull reset
	assign cause_d = '{overflow: overflow,
	                   bad_key:  bad_key && enabled,
	                   early:    early};

	// Configuration register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg_q <= '{timeout_select:  WDT_TOSEL_RST,
			           wd_clock_select: WDT_CLKSEL_RST,
			           window_enable:   WDT_WINEN_RST};
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// Watchdog counter
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Reset request, held until the system reset lands
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			req_q   <= 1'b0;
			cause_q <= '0;
		end else if (|cause_d) begin
			req_q   <= 1'b1;
			cause_q <= cause_q | cause_d;
		end
	end

	// Readback passes through; writes never alter it
	assign reset_status_reg = srs_status_in;
	assign cfg_out          = cfg_q;
	assign wd_enabled       = enabled;
	assign count_out        = cnt_q;
	assign window_open      = windowed ? in_window : 1'b1;
	assign sys_reset_req    = req_q;
	assign reset_cause      = cause_q;

	// Assertions
	a_reset_defaults: assert property (@(posedge sys_clk)
		srst |=> (cfg_q.timeout_select == WDT_TOSEL_LONG && !cfg_q.wd_clock_select))
		else $error("watchdog not enabled at longest 1 kHz timeout after reset");
	a_disabled_quiet: assert property (@(posedge sys_clk) disable iff (srst)
		!enabled |=> !req_q || $past(req_q))
		else $error("disabled watchdog raised a reset");
	a_service_clears: assert property (@(posedge sys_clk) disable iff (srst)
		restart |=> cnt_q == '0)
		else $error("service did not restart the count");
	a_overflow_reset: assert property (@(posedge sys_clk) disable iff (srst)
		overflow |=> req_q && cause_q.overflow)
		else $error("overflow did not request reset");
	a_bad_key_reset: assert property (@(posedge sys_clk) disable iff (srst)
		(enabled && srs_wr_en && srs_wr_data != WDT_KEY_FIRST
		 && srs_wr_data != WDT_KEY_SECOND)
		|=> req_q && cause_q.bad_key)
		else $error("illegal key did not reset");
	a_lpo_short_lim: assert property (@(posedge sys_clk)
		(!cfg_q.wd_clock_select && cfg_q.timeout_select == WDT_TOSEL_SHORT)
		|-> limit == 19'h00020)
		else $error("1 kHz short limit wrong");
	a_bus_long_lim: assert property (@(posedge sys_clk)
		(cfg_q.wd_clock_select && cfg_q.timeout_select == WDT_TOSEL_LONG)
		|-> limit == 19'h40000 && win_start == 19'h30000)
		else $error("bus long limit or window wrong");
	a_early_reset: assert property (@(posedge sys_clk) disable iff (srst)
		(enabled && windowed && !in_window && srs_wr_en && srs_wr_data == WDT_KEY_FIRST)
		|=> req_q && cause_q.early)
		else $error("early service did not reset");
	a_lpo_no_window: assert property (@(posedge sys_clk) disable iff (srst)
		!cfg_q.wd_clock_select |-> !early)
		else $error("window applied on 1 kHz source");
	a_pair_needed: assert property (@(posedge sys_clk) disable iff (srst)
		(srs_wr_en && srs_wr_data == WDT_KEY_FIRST) |-> !service_done)
		else $error("first key alone completed service");

	c_service: cover property (@(posedge sys_clk) disable iff (srst) restart);
	c_overflow: cover property (@(posedge sys_clk) disable iff (srst) overflow);
	c_early: cover property (@(posedge sys_clk) disable iff (srst) early);
	c_bad_key: cover property (@(posedge sys_clk) disable iff (srst) bad_key);

endmodule

/* hw/wdt_pkg.sv */
/*
 * Shared constants and types for the windowed watchdog timer.
 * Assumes a single 10 MHz system clock and a synchronous active-high reset.
 */
package wdt_pkg;

	// Service key values written to the reset-status address
	localparam logic [15:0] WDT_KEY_FIRST  = 16'h0055;
	localparam logic [15:0] WDT_KEY_SECOND = 16'h00aa;

	// Timeout select encodings
	localparam logic [1:0] WDT_TOSEL_OFF   = 2'h0;
	localparam logic [1:0] WDT_TOSEL_SHORT = 2'h1;
	localparam logic [1:0] WDT_TOSEL_MID   = 2'h2;
	localparam logic [1:0] WDT_TOSEL_LONG  = 2'h3;

	// Reset values of the configuration bits
	localparam logic [1:0] WDT_TOSEL_RST   = WDT_TOSEL_LONG;
	localparam logic       WDT_CLKSEL_RST  = 1'b0;
	localparam logic       WDT_WINEN_RST   = 1'b0;

	// Overflow exponents per source and timeout
	localparam int WDT_LPO_EXP_SHORT = 5;
	localparam int WDT_LPO_EXP_MID   = 8;
	localparam int WDT_LPO_EXP_LONG  = 10;
	localparam int WDT_BUS_EXP_SHORT = 13;
	localparam int WDT_BUS_EXP_MID   = 16;
	localparam int WDT_BUS_EXP_LONG  = 18;

	// Counter width covers the longest bus timeout
	localparam int WDT_CNT_W = 19;

	// Low-power tick period and its length in system clocks
	localparam int WDT_LPO_PERIOD_NS = 1000000;
	localparam int WDT_SYS_PERIOD_NS = 100;
	localparam int WDT_LPO_DIV       = WDT_LPO_PERIOD_NS / WDT_SYS_PERIOD_NS;

	// Watchdog configuration carried as one group
	typedef struct packed {
		logic [1:0] timeout_select;   // 0 disables
		logic       wd_clock_select;  // 0 = 1 kHz, 1 = bus
		logic       window_enable;    // Bus clock only
	} wdt_cfg_s;

	// Why the watchdog pulled reset
	typedef struct packed {
		logic overflow;   // Count ran out
		logic bad_key;    // Illegal value written
		logic early;      // Service before window opened
	} wdt_cause_s;

endpackage

/* hw/wdt_tick.sv */
/*
 * Divides the system clock down to the 1 kHz counting tick.
 * Assumes sys_clk at the package rate; the divider restarts on srst.
 */
module wdt_tick
	import wdt_pkg::*;
#(
	parameter int DIV = WDT_LPO_DIV
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic srst,
	// Output tick, one cycle per period
	output logic      tick
);

	localparam int W = $clog2(DIV);

	logic [W-1:0] div_q;   // Divider count
	logic [W-1:0] div_d;   // Next divider count
	logic         wrap;    // Terminal count reached

	// Wrap at DIV-1 so the period is exactly DIV clocks
	assign wrap  = (div_q == W'(DIV - 1));
	assign div_d = wrap ? '0 : div_q + W'(1);
	assign tick  = wrap;

	// Divider register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

endmodule

/* hw/wdt_keyseq.sv */
/*
 * Recognises the ordered two-key service sequence on reset-status writes.
 * Assumes one write strobe per access, synchronous to sys_clk.
 */
module wdt_keyseq
	import wdt_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// Write to the reset-status address
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	// Decoded results, combinational
	output logic            key_first,
	output logic            service_done,
	output logic            bad_key
);

	typedef enum logic [0:0] {
		KS_IDLE  = 1'b0,
		KS_ARMED = 1'b1
	} wdt_ks_e;

	wdt_ks_e state_q;   // Sequence state
	wdt_ks_e state_d;   // Next sequence state
	logic    is_first;  // First key seen
	logic    is_second; // Second key seen

	assign is_first     = (wr_data == WDT_KEY_FIRST);
	assign is_second    = (wr_data == WDT_KEY_SECOND);
	assign key_first    = wr_en && is_first;
	// Second key completes only after the first
	assign service_done = wr_en && is_second && (state_q == KS_ARMED);
	// Any other value is illegal
	assign bad_key      = wr_en && !is_first && !is_second;

	// Next state; repeated first key re-arms
	always_comb begin
		state_d = state_q;
		if (wr_en) begin
			unique case (state_q)
				KS_IDLE: begin
					state_d = is_first ? KS_ARMED : KS_IDLE;
				end
				KS_ARMED: begin
					state_d = is_first ? KS_ARMED : KS_IDLE;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_q <= KS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

endmodule

/* verif/test_windowed_watchdog_timer.sv */
/*
 * Self-checking bench for the watchdog top: defaults, timeouts, service,
 * illegal keys and windowed mode.
 * Assumes wdt_pkg is compiled first and the tick divider is shortened to 4.
 */
module test_windowed_watchdog_timer;
	import wdt_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int DIV = 4;      // Short tick keeps the run small
	localparam int CEIL = 60000; // Whole run needs about 25000 cycles

	// Design ports
	logic                 sys_clk, srst, cfg_we, srs_wr_en;
	wdt_cfg_s             cfg_in, cfg_out;
	wdt_cause_s           reset_cause;
	logic [15:0]          srs_wr_data;
	logic [7:0]           srs_status_in, reset_status_reg;
	logic                 wd_enabled, window_open, sys_reset_req;
	logic [WDT_CNT_W-1:0] count_out;
	int                   n_mismatch, compares, cyc;

	`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
		$display("ERROR %s expected %h seen %h", nm, e, g); n_mismatch++; end end

	wdt_top #(.LPO_DIV(DIV)) u_dut (.sys_clk(sys_clk), .srst(srst), .cfg_in(cfg_in),
		.cfg_we(cfg_we), .srs_wr_en(srs_wr_en), .srs_wr_data(srs_wr_data),
		.srs_status_in(srs_status_in), .reset_status_reg(reset_status_reg),
		.cfg_out(cfg_out), .wd_enabled(wd_enabled), .count_out(count_out),
		.window_open(window_open), .sys_reset_req(sys_reset_req),
		.reset_cause(reset_cause));

	// Free-running clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// Hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == CEIL) begin
			n_mismatch++;
			results();
		end
	end

	// Reset held three cycles; strobes cleared with it
	task automatic do_reset();
		@(posedge sys_clk);
		srst <= 1'b1;
		srs_wr_en <= 1'b0;
		cfg_we <= 1'b0;
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
	endtask

	// One-cycle config load
	task automatic set_cfg(input logic [1:0] ts, input logic cs, input logic we);
		@(posedge sys_clk);
		cfg_in <= '{timeout_select: ts, wd_clock_select: cs, window_enable: we};
		cfg_we <= 1'b1;
		@(posedge sys_clk);
		cfg_we <= 1'b0;
	endtask

	// Single write; the leading edge keeps strobes from colliding
	task automatic wr(input logic [15:0] d);
		@(posedge sys_clk);
		srs_wr_en <= 1'b1;
		srs_wr_data <= d;
		@(posedge sys_clk);
		srs_wr_en <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask

	// Idle for n cycles, then sample settled outputs
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Quiet until clks-slack, then the request must rise within 2*slack
	task automatic chk_ovf(input int clks, input int slack);
		int k;
		idle(clks - slack);
		`CHK("req_quiet", 1'b0, sys_reset_req)
		k = 0;
		while (sys_reset_req !== 1'b1 && k < 2 * slack) begin
			idle(1);
			k++;
		end
		`CHK("req_ovf", 1'b1, sys_reset_req)
		`CHK("cause_ovf", 1'b1, reset_cause.overflow)
	endtask

	// Defaults after reset and the status mirror
	task automatic t_defaults();
		do_reset();
		idle(2);
		`CHK("cfg_rst", 4'hc, cfg_out)
		`CHK("enabled", 1'b1, wd_enabled)
		srs_status_in <= 8'ha3;
		wr(16'h0055);
		`CHK("status", 8'ha3, reset_status_reg)
		chk_ovf(1024 * DIV - 8, 8);
		$display("test defaults done");
	endtask

	// Every timeout code on the 1 kHz source, short on the bus clock, off on both sources
	task automatic t_timeouts();
		int lim [3] = '{32, 256, 1024};
		for (int i = 1; i <= 3; i++) begin
			do_reset();
			set_cfg(i[1:0], 1'b0, 1'b0);
			chk_ovf(lim[i-1] * DIV, 8);
		end
		do_reset();
		set_cfg(2'h1, 1'b1, 1'b0);
		chk_ovf(8192, 4);
		for (int c = 0; c < 2; c++) begin
			do_reset();
			set_cfg(2'h0, c[0], 1'b0);
			idle(300);
			`CHK("off_en", 1'b0, wd_enabled)
			`CHK("off_cnt", 19'h0, count_out)
			`CHK("off_req", 1'b0, sys_reset_req)
		end
		$display("test timeouts done");
	endtask

	// Lone second key ignored; service restarts; repeated first key re-arms
	task automatic t_service();
		do_reset();
		set_cfg(2'h1, 1'b0, 1'b0);
		idle(60);
		wr(16'h00aa);
		`CHK("lone_aa", 1'b0, sys_reset_req)
		idle(40);
		wr(16'h0055);
		wr(16'h00aa);
		`CHK("svc_cnt", 1'b1, count_out <= 1)
		idle(60);
		wr(16'h0055);
		wr(16'h0055);
		wr(16'h00aa);
		`CHK("rearm_cnt", 1'b1, count_out <= 1)
		`CHK("rearm_req", 1'b0, sys_reset_req)
		chk_ovf(32 * DIV, 8);
		$display("test service done");
	endtask

	// Illegal values reset at once; a disabled watchdog stays quiet
	task automatic t_badkey();
		logic [15:0] v [3] = '{16'h0000, 16'h00ff, 16'h0155};
		for (int i = 0; i < 3; i++) begin
			do_reset();
			set_cfg(i == 2 ? 2'h0 : 2'h3, 1'b0, 1'b0);
			wr(v[i]);
			`CHK("bad_req", (i != 2), sys_reset_req)
			`CHK("bad_cause", (i != 2), reset_cause.bad_key)
		end
		$display("test badkey done");
	endtask

	// Window on bus clock; ignored on the 1 kHz source
	task automatic t_window();
		do_reset();
		set_cfg(2'h1, 1'b1, 1'b1);
		idle(10);
		wr(16'h0055);
		`CHK("early_req", 1'b1, sys_reset_req)
		`CHK("early_cause", 1'b1, reset_cause.early)
		do_reset();
		set_cfg(2'h1, 1'b1, 1'b1);
		idle(6144 - 6);
		`CHK("win_shut", 1'b0, window_open)
		idle(10);
		`CHK("win_open", 1'b1, window_open)
		wr(16'h0055);
		wr(16'h00aa);
		`CHK("win_svc", 1'b1, count_out <= 1)
		`CHK("win_req", 1'b0, sys_reset_req)
		do_reset();
		set_cfg(2'h1, 1'b0, 1'b1);
		idle(10);
		wr(16'h0055);
		wr(16'h00aa);
		`CHK("lpo_req", 1'b0, sys_reset_req)
		$display("test window done");
	endtask

	// Counts, verdict, end of run
	task automatic results();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence
	initial begin
		{srst, cfg_we, srs_wr_en, n_mismatch, compares, cyc} = '0;
		cfg_in = '0;
		srs_wr_data = 16'h0000;
		srs_status_in = 8'h5a;
		t_defaults();
		t_timeouts();
		t_service();
		t_badkey();
		t_window();
		results();
	end
endmodule
